// >>> sadc_analog_model.sv
// Behavioural analog front end: channel levels and comparator
`timescale 1ns/100ps
module sadc_analog_model (
  input  wire [4:0] mux_sel,
  input  wire [9:0] dac_code,
  input  wire       conv_power_on,
  output wire       cmp_above
);
  // ======
  // Levels
  wire [9:0] level;
  assign level = (mux_sel == 5'h1D) ? 10'h3FF :
                 (mux_sel == 5'h1E) ? 10'h000 :
                 {mux_sel[2:0], 7'h35};
  // Unpowered, toggle with the code so stale answers show
  assign cmp_above = conv_power_on ? (level >= dac_code)
                                   : ~dac_code[0];
endmodule // sadc_analog_model

// >>> sadc_control.v
// Converter control, result formatting and AHB-Lite register slave
//
// Contract
// - One of eight pins routed by channel select to the converter.
// - Selected pin forced to converter input, port logic overridden.
// - Selected pin ignores port writes and reads back as zero.
// - Unselected pins remain ordinary general-purpose input/output.
// - Ten-bit code, full scale at high reference, zero at low.
// - Conversion starts on control write, lasts 16 or 17 clocks.
// - At end, result stored then flag set or interrupt raised.
// - Continuous mode restarts and overwrites until the bit clears.
// - Completion flag set each conversion, held until data read.
// - Single mode converts once per control write, then idles.
// - Four result formats chosen by two clock register mode bits.
// - Left: eight MSBs high register, two LSBs low register.
// - Low read must follow high read; new results held off.
// - Right: two MSBs high register, eight LSBs low register.
// - Signed: as left justified with result MSB inverted.
// - Truncation: eight MSBs in low register, no interlock.
// - Five-bit select: pins 0-7, high and low references.
// - All-ones select powers down; exit needs one settling cycle.
// - With irq enabled flag reads zero; irq cleared by read/write.
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "sadc_defines.vh"

module sadc_control #(
  parameter RES_W = 10,
  parameter NPIN  = 8
) (
  input  wire            clk,
  input  wire            rst_n,
  input  wire            hsel,
  input  wire [7:0]      haddr,
  input  wire [1:0]      htrans,
  input  wire            hwrite,
  input  wire [2:0]      hsize,
  input  wire [31:0]     hwdata,
  input  wire            hready,
  output reg  [31:0]     hrdata,
  output wire            hreadyout,
  output wire            hresp,
  input  wire            cmp_above,
  output reg  [RES_W-1:0] dac_code,
  output reg  [4:0]      mux_sel,
  output reg             conv_power_on,
  input  wire [NPIN-1:0] pin_in,
  output reg  [NPIN-1:0] pin_out,
  output reg  [NPIN-1:0] pin_oe,
  output reg             conv_irq
);

  // ========================================================
  // Reset release
  reg rst_s1;
  reg rst_s2;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // ========================================================
  // Pin input filter, change taken once stages two and three agree
  reg [NPIN-1:0] pin_s1;
  reg [NPIN-1:0] pin_s2;
  reg [NPIN-1:0] pin_s3;
  reg [NPIN-1:0] pin_q;

  always @(posedge clk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      pin_s1 <= {NPIN{1'b0}};
      pin_s2 <= {NPIN{1'b0}};
      pin_s3 <= {NPIN{1'b0}};
      pin_q  <= {NPIN{1'b0}};
    end
    else
    begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q  <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 ^ pin_s3));
    end
  end

  // ========================================================
  // Functions
  function sel_is_pin;
    input [4:0] ch;
    begin
      sel_is_pin = (ch[4:3] == 2'b00);
    end
  endfunction

  function [7:0] pin_mask;
    input [4:0] ch;
    begin
      pin_mask = sel_is_pin(ch) ? (8'h01 << ch[2:0]) : 8'h00;
    end
  endfunction

  // ========================================================
  // AHB-Lite slave, zero wait states
  reg        ap_valid;
  reg        ap_write;
  reg [7:0]  ap_addr;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge clk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end
    else if (hready)
    begin
      ap_valid <= hsel & htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr;
    end
  end

  wire rd_phase = hsel & htrans[1] & hready & ~hwrite;
  wire wr_phase = ap_valid & ap_write;
  wire wr_scr   = wr_phase && ap_addr == `SADC_OFS_SCR;
  wire wr_clk   = wr_phase && ap_addr == `SADC_OFS_CLK;
  wire wr_dat   = wr_phase && ap_addr == `SADC_OFS_PORT_DAT;
  wire wr_dir   = wr_phase && ap_addr == `SADC_OFS_PORT_DIR;
  wire rd_resh  = rd_phase && haddr == `SADC_OFS_RESH;
  wire rd_resl  = rd_phase && haddr == `SADC_OFS_RESL;

  // ========================================================
  // Registers
  reg       irq_en;
  reg       cont;
  reg [4:0] chan;
  reg [2:0] clk_div;
  reg       clk_src;
  reg [1:0] fmt;
  reg       conversion_complete_flag;
  reg       locked;
  reg [7:0] res_hi;
  reg [7:0] res_lo;
  reg [7:0] port_dat;
  reg [7:0] port_dir;

  // Converter clock: divide by 2^div, source select picks raw clock
  reg  [7:0] div_cnt;
  wire [7:0] div_top = (8'h01 << clk_div) - 8'h01;
  wire conv_tick = clk_src | (div_cnt == div_top);

  always @(posedge clk or negedge rst_s2)
  begin
    if (!rst_s2)
      div_cnt <= 8'h00;
    else if (div_cnt >= div_top)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  wire             core_busy;
  wire             core_done;
  wire [RES_W-1:0] core_result;
  wire [RES_W-1:0] core_trial;
  reg              start;
  reg              was_off;
  wire             powered = (chan != `SADC_CH_OFF);

  sadc_sar_core #(
    .RES_W (RES_W)
  ) u_core (
    .clk       (clk),
    .rst_n     (rst_s2),
    .conv_tick (conv_tick),
    .start     (start),
    .settle    (was_off),
    .cmp_above (cmp_above),
    .trial     (core_trial),
    .busy      (core_busy),
    .done      (core_done),
    .result    (core_result)
  );

  // Formatted result images
  reg [7:0] fmt_hi;
  reg [7:0] fmt_lo;

  always @*
  begin
    case (fmt)
      `SADC_FMT_LEFT:
      begin
        fmt_hi = core_result[9:2];
        fmt_lo = {core_result[1:0], 6'h00};
      end
      `SADC_FMT_RIGHT:
      begin
        fmt_hi = {6'h00, core_result[9:8]};
        fmt_lo = core_result[7:0];
      end
      `SADC_FMT_SIGNED:
      begin
        fmt_hi = {~core_result[9], core_result[8:2]};
        fmt_lo = {core_result[1:0], 6'h00};
      end
      default:
      begin
        fmt_hi = 8'h00;
        fmt_lo = core_result[9:2];
      end
    endcase
  end

  wire trunc = (fmt == `SADC_FMT_TRUNC);

  always @(posedge clk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      irq_en   <= 1'b0;
      cont     <= 1'b0;
      chan     <= 5'h1F;
      clk_div  <= 3'h0;
      clk_src  <= 1'b0;
      fmt      <= 2'h0;
      conversion_complete_flag     <= 1'b0;
      conv_irq <= 1'b0;
      locked   <= 1'b0;
      res_hi   <= 8'h00;
      res_lo   <= 8'h00;
      port_dat <= 8'h00;
      port_dir <= 8'h00;
      start    <= 1'b0;
      was_off  <= 1'b0;
    end
    else
    begin
      start <= 1'b0;
      if (wr_clk)
      begin
        clk_div <= hwdata[`SADC_CLK_DIV_LSB+2:`SADC_CLK_DIV_LSB];
        clk_src <= hwdata[`SADC_CLK_SRC];
        fmt     <= {hwdata[`SADC_CLK_MODE_HI], hwdata[`SADC_CLK_MODE_LO]};
      end
      if (wr_dat)
        port_dat <= hwdata[7:0];
      if (wr_dir)
        port_dir <= hwdata[7:0];
      // Data reads clear the flag; a completion in the same cycle wins
      if (rd_resh || rd_resl)
      begin
        conversion_complete_flag     <= 1'b0;
        conv_irq <= 1'b0;
      end
      if (rd_resl)
        locked <= 1'b0;
      if (wr_scr)
      begin
        irq_en   <= hwdata[`SADC_SCR_IEN];
        cont     <= hwdata[`SADC_SCR_CONT];
        chan     <= hwdata[4:0];
        conv_irq <= 1'b0;
        was_off  <= ~powered;
        // Every control write starts a conversion unless powered down
        start    <= (hwdata[4:0] != `SADC_CH_OFF);
      end
      else if (core_done && cont && powered)
      begin
        start   <= 1'b1;
        was_off <= 1'b0;
      end
      if (core_done && !(locked && !trunc))
      begin
        res_hi <= fmt_hi;
        res_lo <= fmt_lo;
        locked <= ~trunc;
        if (irq_en)
          conv_irq <= 1'b1;
        else
          conversion_complete_flag <= 1'b1;
      end
    end
  end

  // ========================================================
  // Analog mux and shared pin control
  always @*
  begin
    mux_sel       = chan;
    conv_power_on = powered;
    dac_code      = core_trial;
    // Selected pin released to the converter, others stay as port
    pin_oe  = port_dir & ~pin_mask(chan);
    pin_out = port_dat & ~pin_mask(chan);
  end

  // ========================================================
  // Read data, registered for the data phase
  wire [7:0] scr_rd = {conversion_complete_flag & ~irq_en, irq_en, cont, chan};

  always @(posedge clk or negedge rst_s2)
  begin
    if (!rst_s2)
      hrdata <= 32'h0000_0000;
    else if (rd_phase)
    begin
      case (haddr)
        `SADC_OFS_SCR:      hrdata <= {24'h000000, scr_rd};
        `SADC_OFS_RESH:     hrdata <= {24'h000000, res_hi};
        `SADC_OFS_RESL:     hrdata <= {24'h000000, res_lo};
        `SADC_OFS_CLK:      hrdata <= {24'h000000, clk_div, clk_src,
                                       fmt, 2'h0};
        `SADC_OFS_PORT_DAT: hrdata <= {24'h000000, port_dat};
        `SADC_OFS_PORT_DIR: hrdata <= {24'h000000, port_dir};
        // Pin in use by the converter reads zero
        `SADC_OFS_PORT_IN:  hrdata <= {24'h000000,
                                       pin_q & ~pin_mask(chan)};
        default:            hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // sadc_control

// >>> sadc_control_props.sv
// Port checker for the converter control block
`timescale 1ns/100ps
module sadc_control_props #(
  parameter NPIN = 8
) (
  input wire            clk,
  input wire            rst_n,
  input wire            hsel,
  input wire [7:0]      haddr,
  input wire [1:0]      htrans,
  input wire            hwrite,
  input wire [31:0]     hwdata,
  input wire            hready,
  input wire [31:0]     hrdata,
  input wire            hreadyout,
  input wire            hresp,
  input wire [4:0]      mux_sel,
  input wire            conv_power_on,
  input wire [NPIN-1:0] pin_oe,
  input wire            conv_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ======
  // Data phase tracking
  logic       ap_w;
  logic       ap_r;
  logic [7:0] ap_a;
  logic       ien;
  logic [5:0] since_wr;
  wire        take  = hsel & htrans[1] & hready;
  wire        scr_w = ap_w & (ap_a == 8'h00);
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ap_w     <= 1'b0;
      ap_r     <= 1'b0;
      ap_a     <= 8'h00;
      ien      <= 1'b0;
      since_wr <= 6'h00;
    end
    else
    begin
      ap_w     <= take & hwrite;
      ap_r     <= take & ~hwrite;
      ap_a     <= haddr;
      ien      <= scr_w ? hwdata[6] : ien;
      since_wr <= scr_w ? 6'h00 : since_wr + {5'h00, since_wr != 6'h3F};
    end
  // ======
  // Assertions
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not OKAY");
  pin_free_a: assert property (
    mux_sel < 5'h08 && $stable(mux_sel) |-> !pin_oe[mux_sel[2:0]])
    else $error("selected pin driven");
  power_sel_a: assert property (
    $stable(mux_sel) |-> conv_power_on == (mux_sel != 5'h1F))
    else $error("power does not follow select");
  sel_write_a: assert property ($changed(mux_sel) |-> $past(scr_w))
    else $error("select moved without write");
  irq_clear_a: assert property (
    $fell(conv_irq) |->
    $past(scr_w || take && !hwrite && (haddr == 8'h04 || haddr == 8'h08)))
    else $error("irq dropped without access");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(take && !hwrite))
    else $error("read data moved without read");
  conv_len_a: assert property ($rose(conv_irq) |-> since_wr >= 6'd16)
    else $error("conversion too short");
  irq_en_a: assert property ($rose(conv_irq) |-> ien)
    else $error("irq while disabled");
  cover property ($rose(conv_irq));
  cover property ($fell(conv_irq));
  cover property (ap_r && ap_a == 8'h08);
endmodule // sadc_control_props

bind sadc_control sadc_control_props #(.NPIN(NPIN)) chk_u (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .mux_sel(mux_sel), .conv_power_on(conv_power_on), .pin_oe(pin_oe),
  .conv_irq(conv_irq)
);

// >>> sadc_defines.vh
// Register map, field positions, reset values and timing counts
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH

// ==========================================================
// Register byte offsets
`define SADC_OFS_SCR      8'h00
`define SADC_OFS_RESH     8'h04
`define SADC_OFS_RESL     8'h08
`define SADC_OFS_CLK      8'h0C
`define SADC_OFS_PORT_DAT 8'h10
`define SADC_OFS_PORT_DIR 8'h14
`define SADC_OFS_PORT_IN  8'h18

// ==========================================================
// Status/control fields
`define SADC_SCR_CONVERSION_COMPLETE_FLAG     7
`define SADC_SCR_IEN      6
`define SADC_SCR_CONT     5
`define SADC_CH_LSB       0
`define SADC_CH_W         5
`define SADC_SCR_RST      8'h1F

// ==========================================================
// Clock register fields
`define SADC_CLK_DIV_LSB  5
`define SADC_CLK_DIV_W    3
`define SADC_CLK_SRC      4
`define SADC_CLK_MODE_HI  3
`define SADC_CLK_MODE_LO  2
`define SADC_CLK_RST      8'h00

// ==========================================================
// Channel codes and formats
`define SADC_CH_REFH      5'h1D
`define SADC_CH_REFL      5'h1E
`define SADC_CH_OFF       5'h1F
`define SADC_FMT_LEFT     2'h0
`define SADC_FMT_RIGHT    2'h1
`define SADC_FMT_SIGNED   2'h2
`define SADC_FMT_TRUNC    2'h3

// ==========================================================
// Conversion timing in converter clock cycles
`define SADC_CONV_CYCLES  16
`define SADC_CONV_EXTRA   1

`endif

// >>> sadc_sar_core.v
// Successive-approximation sequencer with conversion timing
`timescale 1ns/100ps
`include "sadc_defines.vh"

module sadc_sar_core #(
  parameter RES_W = 10
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             conv_tick,
  input  wire             start,
  input  wire             settle,
  input  wire             cmp_above,
  output reg  [RES_W-1:0] trial,
  output reg              busy,
  output reg              done,
  output reg  [RES_W-1:0] result
);

  // ========================================================
  // Sequencer
  localparam integer LAST_I  = `SADC_CONV_CYCLES - 1;
  localparam [4:0]   LAST_CYC = LAST_I[4:0];
  reg [4:0]       cyc;
  reg [RES_W-1:0] bit_sel;
  reg             extra;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc     <= 5'h00;
      bit_sel <= {RES_W{1'b0}};
      trial   <= {RES_W{1'b0}};
      busy    <= 1'b0;
      done    <= 1'b0;
      extra   <= 1'b0;
      result  <= {RES_W{1'b0}};
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        // Restart drops any partial result
        busy    <= 1'b1;
        cyc     <= 5'h00;
        extra   <= settle;
        bit_sel <= {1'b1, {(RES_W-1){1'b0}}};
        trial   <= {1'b1, {(RES_W-1){1'b0}}};
      end
      else if (busy && conv_tick)
      begin
        // Binary search runs in the first bit cycles, rest is sampling
        if (bit_sel != {RES_W{1'b0}} && !extra)
        begin
          if (!cmp_above)
            trial <= trial & ~bit_sel;
          bit_sel <= bit_sel >> 1;
          if (bit_sel[0] == 1'b0)
            trial <= (cmp_above ? trial : (trial & ~bit_sel))
                     | (bit_sel >> 1);
        end
        if (extra)
          extra <= 1'b0;
        else if (cyc == LAST_CYC)
        begin
          busy   <= 1'b0;
          done   <= 1'b1;
          result <= trial;
        end
        else
          cyc <= cyc + 5'h01;
      end
    end
  end

endmodule // sadc_sar_core

// >>> tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module tb;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [7:0]  pin_in;
  logic [31:0] q;
  int          err_total;
  int          compares;
  wire  [31:0] hrdata;
  wire  [9:0]  dac_code;
  wire  [4:0]  mux_sel;
  wire  [7:0]  pin_out;
  wire  [7:0]  pin_oe;
  wire         hreadyout, hresp, cmp_above, conv_power_on, conv_irq;

  sadc_control dut_u (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cmp_above(cmp_above), .dac_code(dac_code),
    .mux_sel(mux_sel), .conv_power_on(conv_power_on), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .conv_irq(conv_irq)
  );
  sadc_analog_model afe_u (
    .mux_sel(mux_sel), .dac_code(dac_code),
    .conv_power_on(conv_power_on), .cmp_above(cmp_above)
  );

  // ======
  // Bus and checking
  task automatic chk(input [31:0] got, input [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task tally_and_finish;
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task die;
    err_total++;
    tally_and_finish;
  endtask

  task automatic hwait;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
        die;
      @(posedge clk);
    end
  endtask

  // Read data taken at the data-phase edge, before the design updates
  task automatic bus(input w, input [7:0] a, input [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    hwait;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    q = hrdata;
  endtask

  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_flag;
    int n;
    for (n = 0; n < 40; n++)
    begin
      rd(8'h00);
      if (q[7] === 1'b1)
        return;
    end
    die;
  endtask

  // ======
  // Scenarios; pin 3 sits at 1B5
  task automatic t_formats;
    logic [7:0] h;
    int         f;
    for (f = 0; f < 4; f++)
    begin
      wr(8'h0C, 32'h10 | (f << 2));
      wr(8'h00, 32'h03);
      wait_flag;
      rd(8'h04);
      h = q[7:0];
      rd(8'h08);
      case (f)
        0: chk(h, 8'h6D);
        1: chk({h, q[7:0]}, 16'h01B5);
        2: chk(h, 8'hED);
        default: chk(q[7:0], 8'h6D);
      endcase
      rd(8'h00);
      chk(q[7], 1'b0);
    end
  endtask

  task t_port;
    wr(8'h14, 32'hFF);
    wr(8'h10, 32'hAA);
    wr(8'h00, 32'h03);
    rd(8'h18);
    chk(q[7:0], 8'h54);
    chk(pin_oe, 8'hF7);
    chk(pin_out, 8'hA2);
    wait_flag;
    rd(8'h08);
  endtask

  task automatic t_irq;
    int n;
    wr(8'h0C, 32'h14);
    wr(8'h00, 32'h5D);
    for (n = 0; n < 60 && conv_irq !== 1'b1; n++)
      @(posedge clk);
    if (n == 60)
      die;
    rd(8'h00);
    chk(q[7], 1'b0);
    rd(8'h04);
    chk(q[7:0], 8'h03);
    rd(8'h08);
    chk(q[7:0], 8'hFF);
    chk(conv_irq, 1'b0);
  endtask

  task t_lock;
    wr(8'h0C, 32'h10);
    wr(8'h00, 32'h1D);
    wait_flag;
    rd(8'h04);
    chk(q[7:0], 8'hFF);
    wr(8'h00, 32'h1E);
    repeat (40) @(posedge clk);
    rd(8'h04);
    chk(q[7:0], 8'hFF);
    rd(8'h08);
    wr(8'h00, 32'h1E);
    wait_flag;
    rd(8'h04);
    chk(q[7:0], 8'h00);
    rd(8'h08);
  endtask

  task t_cont;
    wr(8'h0C, 32'h1C);
    wr(8'h00, 32'h3E);
    wait_flag;
    rd(8'h08);
    chk(q[7:0], 8'h00);
    wait_flag;
    chk(q[7], 1'b1);
    wr(8'h00, 32'h1F);
    repeat (40) @(posedge clk);
    rd(8'h08);
    wr(8'h00, 32'h1D);
    wait_flag;
    rd(8'h08);
    chk(q[7:0], 8'hFF);
    repeat (40) @(posedge clk);
    rd(8'h00);
    chk(q[7], 1'b0);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    err_total = 0;
    compares  = 0;
    rst_n     = 1'b0;
    hsel      = 1'b0;
    haddr     = 8'h00;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hwdata    = 32'h0;
    pin_in    = 8'h5C;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h00);
    chk(q[7:0], 8'h1F);
    chk(conv_power_on, 1'b0);
    t_formats;
    t_port;
    t_irq;
    t_lock;
    t_cont;
    tally_and_finish;
  end
endmodule // tb
